// ==== tb_mcu_external_bus_port.sv ====
module tb_mcu_external_bus_port;
  import xbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, rst_pin, ext_access_select, prog_verify_pin, core_fetch_req, xdata_req;
  logic xdata_write, port_wr, core_txd, ale, prog_store_strobe_n, core_reset, fetch_valid;
  logic xdata_busy, xdata_done, rxd, ext_irq_a, ext_irq_b, counter_in_a, counter_in_b, mem_en;
  logic [1:0] port_sel;
  logic [ADDR_W-1:0] core_pc, xdata_addr;
  logic [IROM_AW-1:0] irom_addr;
  logic [PORT_W-1:0] p0_in, p1_in, p2_in, p3_in, p0_out, p1_out, p2_out, p3_out, p0_oe_n;
  logic [PORT_W-1:0] p1_oe_n, p2_oe_n, p3_oe_n, fetch_data, xdata_wdata, xdata_rdata;
  logic [PORT_W-1:0] port_wdata, irom_data, pin_p0, pin_p1, pin_p2, pin_p3;
  logic [PORT_W-1:0] p1_ext, p2_ext, p3_ext, mem_d, p0_hold;
  int err_count, comparisons;

  // clk stands in for the oscillator itself
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ====================
  // pins: released low port shows a toggling pattern
  assign irom_data = irom_addr[7:0] ^ 8'h3c;
  assign p0_in = (~p0_oe_n & p0_out) | (p0_oe_n & (mem_en ? mem_d : ~p0_hold));
  assign p1_in = p1_ext & (p1_oe_n | p1_out);
  assign p2_in = p2_ext & (p2_oe_n | p2_out);
  assign p3_in = p3_ext & (p3_oe_n | p3_out);
  always @(posedge clk) p0_hold <= p0_in;

  xbp_port dut (.*);
  xbp_xmem mem (.clk(clk), .ale(ale), .prog_store_strobe_n(prog_store_strobe_n),
    .p0_pin(p0_in), .p2_pin(p2_in), .rd_n(p3_out[P3_RD]), .wr_n(p3_out[P3_WR]),
    .mem_d(mem_d), .mem_en(mem_en));

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic note(input string s);
    $display("test %s finished, mismatches %0d", s, err_count);
  endtask

  task automatic do_fetch(input logic [15:0] pc, input logic ext);
    logic [7:0] exp;
    logic seen;
    int n;
    exp = ext ? (pc[7:0] + pc[15:8]) ^ 8'hc3 : pc[7:0] ^ 8'h3c;
    seen = 1'b0;
    n = 0;
    @(posedge clk);
    core_pc <= pc;
    core_fetch_req <= 1'b1;
    do begin
      @(posedge clk);
      #1;
      seen |= !prog_store_strobe_n;
      n++;
    end while (fetch_valid !== 1'b1 && n < 40);
    check8(fetch_valid, 1'b1);
    check8(fetch_data, exp);
    check8(seen, ext);
    @(posedge clk);
    core_fetch_req <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  task automatic do_x(input logic wr, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    xdata_req <= 1'b1;
    xdata_write <= wr;
    xdata_addr <= a;
    xdata_wdata <= d;
    @(posedge clk);
    xdata_req <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (xdata_done !== 1'b1 && n < 60);
    check8(xdata_done, 1'b1);
    check8(xdata_busy, 1'b0);
    if (!wr) check8(xdata_rdata, d);
  endtask

  task automatic port_write(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk);
    port_wr <= 1'b1;
    port_sel <= s;
    port_wdata <= d;
    @(posedge clk);
    port_wr <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic t_fetch;
    do_fetch(16'h0123, 1'b0);
    do_fetch(16'h0fff, 1'b0);
    do_fetch(16'h1000, 1'b1);
    do_fetch(16'hffff, 1'b1);
    @(posedge clk);
    ext_access_select <= 1'b0;
    repeat (6) @(posedge clk);
    do_fetch(16'h0123, 1'b1);
    ext_access_select <= 1'b1;
    repeat (6) @(posedge clk);
    note("fetch");
  endtask

  task automatic t_xdata;
    do_x(1'b1, 16'hffff, 8'ha5);
    do_x(1'b1, 16'h0000, 8'h5a);
    do_x(1'b0, 16'hffff, 8'ha5);
    do_x(1'b0, 16'h0000, 8'h5a);
    note("data");
  endtask

  task automatic t_ports;
    port_write(2'h1, 8'h5a);
    check8(p1_out, 8'h5a);
    port_write(2'h3, 8'hf7);
    check8(ext_irq_b, 1'b0);
    check8(counter_in_a, 1'b1);
    check8(p3_out, 8'hf7);
    check8(p3_oe_n, 8'hf7);
    check8(rxd, 1'b1);
    check8(ext_irq_a, 1'b1);
    check8(counter_in_b, 1'b1);
    @(posedge clk);
    core_txd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check8(p3_out, 8'hf5);
    @(posedge clk);
    core_txd <= 1'b1;
    port_write(2'h3, 8'hfd);
    check8(p3_out, 8'hfd);
    port_write(2'h3, 8'hff);
    check8(ext_irq_b, 1'b1);
    note("ports");
  endtask

  task automatic t_verify;
    @(posedge clk);
    prog_verify_pin <= 1'b1;
    p1_ext <= 8'h34;
    p2_ext <= 8'h72;
    repeat (12) @(posedge clk);
    #1;
    check8(p0_oe_n, 8'h00);
    check8(p0_out, 8'h34 ^ 8'h3c);
    check8({4'h0, irom_addr[11:8]}, 8'h02);
    @(posedge clk);
    prog_verify_pin <= 1'b0;
    p1_ext <= 8'hff;
    p2_ext <= 8'hff;
    repeat (12) @(posedge clk);
    note("verify");
  endtask

  task automatic t_reset;
    @(posedge clk);
    rst_pin <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    check8(core_reset, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    check8(core_reset, 1'b1);
    check8(p1_out, 8'hff);
    @(posedge clk);
    rst_pin <= 1'b0;
    repeat (12) @(posedge clk);
    #1;
    check8(core_reset, 1'b0);
    note("reset");
  endtask

  initial begin
    reset = 1'b1;
    rst_pin = 1'b0;
    ext_access_select = 1'b1;
    prog_verify_pin = 1'b0;
    core_fetch_req = 1'b0;
    core_pc = '0;
    xdata_req = 1'b0;
    xdata_write = 1'b0;
    xdata_addr = '0;
    xdata_wdata = '0;
    port_wr = 1'b0;
    port_sel = 2'h0;
    port_wdata = '0;
    core_txd = 1'b1;
    p1_ext = 8'hff;
    p2_ext = 8'hff;
    p3_ext = 8'hff;
    p0_hold = 8'h00;
    err_count = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (10) @(posedge clk);
    t_fetch();
    t_xdata();
    t_ports();
    t_verify();
    t_reset();
    results();
  end

  // whole run needs well under 2000 cycles
  initial begin
    #100us;
    err_count++;
    results();
  end
endmodule // tb_mcu_external_bus_port

// ==== xbp_pkg.sv ====
package xbp_pkg;

  // =====================================================================
  // widths and sizes
  // =====================================================================
  localparam int PORT_W = 8;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] IROM_SIZE = 16'h1000;
  localparam int IROM_AW = 12;
  localparam int VER_HI_W = IROM_AW - PORT_W;

  // =====================================================================
  // machine cycle timing, counted in oscillator periods (one clk each)
  // =====================================================================
  localparam logic [3:0] PH_LAST = 4'hb;
  localparam logic [3:0] PH_HALF = 4'h6;
  localparam logic [3:0] SUB_ALE_END = 4'h2;
  localparam logic [3:0] SUB_ADDR_END = 4'h3;
  localparam logic [3:0] SUB_STRB_ON = 4'h3;
  localparam logic [3:0] SUB_LAST = 4'h5;
  localparam logic [3:0] PH_XSTRB_ON = 4'h3;
  localparam logic [3:0] PH_XSTRB_OFF = 4'ha;
  localparam logic [3:0] PH_XSAMPLE = 4'h9;

  // reset pin must stay high for two machine cycles
  localparam int RST_HOLD_MC = 2;
  localparam int OSC_PER_MC = 12;
  localparam int RST_HOLD_CYC = RST_HOLD_MC * OSC_PER_MC;
  localparam logic [4:0] RST_HOLD_CNT = 5'(RST_HOLD_CYC);

  // =====================================================================
  // reset values and pin positions
  // =====================================================================
  localparam logic [PORT_W-1:0] LATCH_RESET = 8'hff;
  localparam int P3_RXD = 0;
  localparam int P3_TXD = 1;
  localparam int P3_IRQ_A = 2;
  localparam int P3_IRQ_B = 3;
  localparam int P3_CNT_A = 4;
  localparam int P3_CNT_B = 5;
  localparam int P3_WR = 6;
  localparam int P3_RD = 7;
  localparam int VER_OE_BIT = 7;

  typedef enum logic [1:0] {
    XBP_CYC_CODE,
    XBP_CYC_DATA
  } xbp_cyc_e;

endpackage

// ==== xbp_port.sv ====
module xbp_port
  import xbp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic rst_pin,
  input wire logic ext_access_select,
  input wire logic prog_verify_pin,
  input wire logic [PORT_W-1:0] p0_in,
  output logic [PORT_W-1:0] p0_out,
  output logic [PORT_W-1:0] p0_oe_n,
  input wire logic [PORT_W-1:0] p1_in,
  output logic [PORT_W-1:0] p1_out,
  output logic [PORT_W-1:0] p1_oe_n,
  input wire logic [PORT_W-1:0] p2_in,
  output logic [PORT_W-1:0] p2_out,
  output logic [PORT_W-1:0] p2_oe_n,
  input wire logic [PORT_W-1:0] p3_in,
  output logic [PORT_W-1:0] p3_out,
  output logic [PORT_W-1:0] p3_oe_n,
  output logic ale,
  output logic prog_store_strobe_n,
  output logic core_reset,
  input wire logic core_fetch_req,
  input wire logic [ADDR_W-1:0] core_pc,
  output logic [PORT_W-1:0] fetch_data,
  output logic fetch_valid,
  output logic [IROM_AW-1:0] irom_addr,
  input wire logic [PORT_W-1:0] irom_data,
  input wire logic xdata_req,
  input wire logic xdata_write,
  input wire logic [ADDR_W-1:0] xdata_addr,
  input wire logic [PORT_W-1:0] xdata_wdata,
  output logic xdata_busy,
  output logic [PORT_W-1:0] xdata_rdata,
  output logic xdata_done,
  input wire logic port_wr,
  input wire logic [1:0] port_sel,
  input wire logic [PORT_W-1:0] port_wdata,
  output logic [PORT_W-1:0] pin_p0,
  output logic [PORT_W-1:0] pin_p1,
  output logic [PORT_W-1:0] pin_p2,
  output logic [PORT_W-1:0] pin_p3,
  input wire logic core_txd,
  output logic rxd,
  output logic ext_irq_a,
  output logic ext_irq_b,
  output logic counter_in_a,
  output logic counter_in_b
);

  // =====================================================================
  // pin synchronisers
  // =====================================================================
  logic [4*PORT_W-1:0] port_sync;
  logic [2:0] ctrl_sync;

  xbp_sync #(
    .WIDTH(4*PORT_W),
    .INIT({4*PORT_W{1'b1}})
  ) u_port_sync (
    .clk(clk),
    .reset(reset),
    .pin({p3_in, p2_in, p1_in, p0_in}),
    .level(port_sync)
  );

  xbp_sync #(
    .WIDTH(3),
    .INIT(3'b010)
  ) u_ctrl_sync (
    .clk(clk),
    .reset(reset),
    .pin({prog_verify_pin, ext_access_select, rst_pin}),
    .level(ctrl_sync)
  );

  wire rst_level = ctrl_sync[0];
  wire sel_level = ctrl_sync[1];
  wire verify = ctrl_sync[2];
  assign pin_p0 = port_sync[PORT_W-1:0];
  assign pin_p1 = port_sync[2*PORT_W-1:PORT_W];
  assign pin_p2 = port_sync[3*PORT_W-1:2*PORT_W];
  assign pin_p3 = port_sync[4*PORT_W-1:3*PORT_W];

  // =====================================================================
  // reset pin qualification
  // =====================================================================
  // the count only runs on clk, so with a stopped oscillator the pin never resets
  logic [4:0] rst_cnt;
  wire rst_held = rst_cnt == RST_HOLD_CNT;
  wire [4:0] next_rst_cnt = !rst_level ? 5'h00 : (rst_held ? rst_cnt : rst_cnt + 5'h01);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_cnt <= '0;
      core_reset <= 1'b1;
    end else begin
      rst_cnt <= next_rst_cnt;
      core_reset <= rst_held || (core_reset && rst_level);
    end
  end

  // =====================================================================
  // machine cycle phase: twelve oscillator periods, two halves of six
  // =====================================================================
  logic [3:0] ph;
  xbp_cyc_e cyc;
  wire ph_end = ph == PH_LAST;
  wire half = ph >= PH_HALF;
  wire [3:0] sub = half ? ph - PH_HALF : ph;
  wire sub_start = sub == 4'h0;
  wire sub_end = sub == SUB_LAST;
  wire data_cyc = cyc == XBP_CYC_DATA;

  // =====================================================================
  // port latches and external data request
  // =====================================================================
  logic [PORT_W-1:0] lat0;
  logic [PORT_W-1:0] lat1;
  logic [PORT_W-1:0] lat2;
  logic [PORT_W-1:0] lat3;
  logic xd_pend;
  logic xd_wr;
  logic [ADDR_W-1:0] xd_addr;
  logic [PORT_W-1:0] xd_wdata;
  wire xd_take = xdata_req && !xd_pend && !core_reset;
  assign xdata_busy = xd_pend;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lat0 <= LATCH_RESET;
      lat1 <= LATCH_RESET;
      lat2 <= LATCH_RESET;
      lat3 <= LATCH_RESET;
    end else if (core_reset) begin
      lat0 <= LATCH_RESET;
      lat1 <= LATCH_RESET;
      lat2 <= LATCH_RESET;
      lat3 <= LATCH_RESET;
    end else if (port_wr) begin
      unique case (port_sel)
        2'd0: lat0 <= port_wdata;
        2'd1: lat1 <= port_wdata;
        2'd2: lat2 <= port_wdata;
        2'd3: lat3 <= port_wdata;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xd_pend <= 1'b0;
      xd_wr <= 1'b0;
      xd_addr <= '0;
      xd_wdata <= '0;
    end else if (core_reset) begin
      xd_pend <= 1'b0;
    end else if (xd_take) begin
      xd_pend <= 1'b1;
      xd_wr <= xdata_write;
      xd_addr <= xdata_addr;
      xd_wdata <= xdata_wdata;
    end else if (data_cyc && ph_end) begin
      xd_pend <= 1'b0;
    end
  end

  // =====================================================================
  // cycle sequencing and fetch source
  // =====================================================================
  logic code_act;
  logic ext_fetch;
  logic [ADDR_W-1:0] fetch_addr;
  wire pc_internal = sel_level && (core_pc < IROM_SIZE);
  wire bus_idle = core_reset || verify;
  wire take_fetch = sub_start && !data_cyc && core_fetch_req && !bus_idle;
  // pend clears on the edge that ends the data cycle; without this it would repeat
  wire next_cyc_data = xd_pend && !data_cyc && !bus_idle;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ph <= '0;
      cyc <= XBP_CYC_CODE;
    end else begin
      ph <= ph_end ? 4'h0 : ph + 4'h1;
      if (ph_end) begin
        cyc <= next_cyc_data ? XBP_CYC_DATA : XBP_CYC_CODE;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      code_act <= 1'b0;
      ext_fetch <= 1'b0;
      fetch_addr <= '0;
    end else if (sub_start) begin
      code_act <= take_fetch;
      ext_fetch <= take_fetch && !pc_internal;
      fetch_addr <= core_pc;
    end
  end

  // =====================================================================
  // bus strobes
  // =====================================================================
  wire ext_half = code_act && ext_fetch && !data_cyc;
  // one pulse is dropped in the data cycle's second half
  assign ale = (sub < SUB_ALE_END) && !(data_cyc && half);
  // strobe is high whenever the half-cycle fetches from internal memory
  assign prog_store_strobe_n = !(ext_half && sub >= SUB_STRB_ON);
  wire addr_phase = sub < SUB_ADDR_END;
  wire xstrb = data_cyc && ph >= PH_XSTRB_ON && ph < PH_XSTRB_OFF;
  wire wr_strb_n = !(xstrb && xd_wr);
  wire rd_strb_n = !(xstrb && !xd_wr);
  wire bus_p0 = ext_half || (data_cyc && !half);
  wire p0_addr = bus_p0 && addr_phase;
  wire p0_wdat = xstrb && xd_wr;
  wire [PORT_W-1:0] bus_lo = data_cyc ? xd_addr[PORT_W-1:0] : fetch_addr[PORT_W-1:0];
  wire [PORT_W-1:0] bus_hi = data_cyc ? xd_addr[ADDR_W-1:PORT_W] : fetch_addr[ADDR_W-1:PORT_W];
  wire p2_bus = ext_half || data_cyc;

  // =====================================================================
  // returned bytes
  // =====================================================================
  wire fetch_sample = code_act && !data_cyc && sub_end;
  wire xd_sample = data_cyc && ph == PH_XSAMPLE;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fetch_data <= '0;
      fetch_valid <= 1'b0;
      xdata_rdata <= '0;
      xdata_done <= 1'b0;
    end else begin
      fetch_valid <= fetch_sample;
      xdata_done <= data_cyc && ph_end;
      // bus bytes answer our own strobes: taken raw, the synced copy lags
      if (fetch_sample) begin
        fetch_data <= ext_fetch ? p0_in : irom_data;
      end
      if (xd_sample && !xd_wr) begin
        xdata_rdata <= p0_in;
      end
    end
  end

  // =====================================================================
  // program verification: address in on ports 1 and 2, byte out on port 0
  // =====================================================================
  wire [IROM_AW-1:0] ver_addr = {pin_p2[VER_HI_W-1:0], pin_p1};
  wire ver_drive = verify && !pin_p2[VER_OE_BIT];
  assign irom_addr = verify ? ver_addr : fetch_addr[IROM_AW-1:0];

  // =====================================================================
  // pin drivers; oe_n low means the pin is driven
  // =====================================================================
  // port 0 sources actively on the bus, sinks only as a plain port
  wire p0_drive = p0_addr || p0_wdat || ver_drive;
  wire [PORT_W-1:0] p0_bus_val = ver_drive ? irom_data : (p0_addr ? bus_lo : xd_wdata);
  assign p0_out = p0_drive ? p0_bus_val : '0;
  assign p0_oe_n = p0_drive ? '0 : lat0;

  // quasi ports: a one is left to the pullup, a zero is pulled down
  assign p1_out = verify ? '1 : lat1;
  assign p1_oe_n = verify ? '1 : lat1;

  wire [PORT_W-1:0] p2_val = p2_bus ? bus_hi : lat2;
  assign p2_out = p2_val;
  assign p2_oe_n = verify ? '1 : (p2_bus ? '0 : p2_val);

  wire [PORT_W-1:0] p3_alt;
  assign p3_alt = {rd_strb_n, wr_strb_n, 4'hf, core_txd, 1'b1};
  wire [PORT_W-1:0] p3_val = lat3 & p3_alt;
  assign p3_out = p3_val;
  assign p3_oe_n = p3_val;

  // =====================================================================
  // port 3 alternate inputs, gated by their latch bits
  // =====================================================================
  wire [PORT_W-1:0] p3_in_alt = pin_p3 & lat3;
  assign rxd = p3_in_alt[P3_RXD];
  assign ext_irq_a = p3_in_alt[P3_IRQ_A];
  assign ext_irq_b = p3_in_alt[P3_IRQ_B];
  assign counter_in_a = p3_in_alt[P3_CNT_A];
  assign counter_in_b = p3_in_alt[P3_CNT_B];

endmodule // xbp_port

// ==== xbp_port_properties.sv ====
module xbp_port_chk
  import xbp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic rst_pin,
  input wire logic ale,
  input wire logic prog_store_strobe_n,
  input wire logic core_reset,
  input wire logic [PORT_W-1:0] p0_oe_n,
  input wire logic [PORT_W-1:0] p2_oe_n,
  input wire logic [PORT_W-1:0] p3_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [4:0] hi_cnt;

  // ====================
  // raw reset pin high run, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hi_cnt <= 5'h00;
    end else if (!rst_pin) begin
      hi_cnt <= 5'h00;
    end else if (hi_cnt != 5'h1f) begin
      hi_cnt <= hi_cnt + 5'h01;
    end
  end

  // ====================
  // strobe sequences
  sequence ale_pulse;
    ale[*2] ##1 !ale;
  endsequence
  sequence strobe_low;
    !prog_store_strobe_n[*3] ##1 prog_store_strobe_n;
  endsequence

  ale_width_a: assert property ($rose(ale) |-> ale_pulse)
    else $error("latch strobe width wrong");
  ale_gap_a: assert property ($fell(ale) |-> !ale[*4] ##1 (ale or (!ale[*6] ##1 ale)))
    else $error("latch strobe spacing wrong");
  store_width_a: assert property ($fell(prog_store_strobe_n) |-> strobe_low)
    else $error("program strobe width wrong");
  store_order_a: assert property ($fell(prog_store_strobe_n) |-> $past(ale, 2) && !$past(ale))
    else $error("program strobe not after latch strobe");
  store_bus_a: assert property (!prog_store_strobe_n |-> p0_oe_n == 8'hff && p2_oe_n == 8'h00)
    else $error("bus drivers wrong in fetch");
  strobe_excl_a: assert property (!(p3_out[P3_RD] && p3_out[P3_WR]) |-> prog_store_strobe_n)
    else $error("program strobe in data access");
  rd_no_ale_a: assert property (!p3_out[P3_RD] |-> !$rose(ale))
    else $error("latch strobe during data read");
  wr_drive_a: assert property (!p3_out[P3_WR] |-> p0_oe_n == 8'h00)
    else $error("low port not driven in write");
  reset_hold_a: assert property ($rose(core_reset) |-> hi_cnt >= 5'h18)
    else $error("reset entered too early");
endmodule // xbp_port_chk

bind xbp_port xbp_port_chk chk (.*);

// ==== xbp_sync.sv ====
module xbp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  // =====================================================================
  // three stages; a change is taken once stages two and three agree
  // =====================================================================
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire [WIDTH-1:0] agree = ~(s2 ^ s3);
  wire [WIDTH-1:0] next_level = (agree & s3) | (~agree & level);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end

endmodule // xbp_sync

// ==== xbp_xmem.sv ====
module xbp_xmem
  import xbp_pkg::*;
(
  input wire logic clk,
  input wire logic ale,
  input wire logic prog_store_strobe_n,
  input wire logic [PORT_W-1:0] p0_pin,
  input wire logic [PORT_W-1:0] p2_pin,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic [PORT_W-1:0] mem_d,
  output logic mem_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // address latch and both memories
  logic [ADDR_W-1:0] lat;
  logic [PORT_W-1:0] xram [0:65535];

  always @(posedge clk) begin
    if (ale) begin
      lat <= {p2_pin, p0_pin};
    end
    if (!wr_n) begin
      xram[lat] <= p0_pin;
    end
  end

  // program bytes are a fold of the address, no storage needed
  assign mem_en = !prog_store_strobe_n || !rd_n;
  assign mem_d = !prog_store_strobe_n ? (lat[7:0] + lat[15:8]) ^ 8'hc3 : xram[lat];
endmodule // xbp_xmem
